// ==== core/config_register_lock.sv ====
// configuration write and permanent lock engine of a serial eeprom client
// assumes serial clock and data arrive unsynchronised; data pin is open drain
`timescale 1ns/1ps
`default_nettype none

// Operation
// - lock bit in write-protect byte commits lock
// - invalid first byte aborts, no ack, no write
// - optional second byte loads client address
// - invalid address byte aborts, no ack, no write
// - stop after first byte completes the lock
// - omitted address byte keeps current address
// - extra data byte aborts, registers unchanged
// - committed lock is cleared only by reset
// - delivered array content is all ones
// - delivered client address is factory preset
// - write-protect is byte 0, address byte 1
// - write-enable bit required, reads as zero
// - check bit must equal lock bit, reads zero
// - address byte needs enable and check match
module config_register_lock #(
  parameter logic [2:0] CLIENT_PRESET = cfg_lock_pkg::CA_PRESET_VAL
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [7:0] WP_BYTE,
  output logic [2:0] CLIENT_ADDR,
  output logic CFG_LOCKED,
  output logic WRITE_CYCLE,
  output logic [7:0] ARRAY_FILL
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and bus event detection
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], SCL};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // byte shifter: bits 0..7 data, bit 8 acknowledge slot
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic byte_done;
  assign byte_done = scl_fall && (bit_cnt_reg == 4'h8);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_ev) begin
      // the clock fall right after a start ends no bit: park one below zero
      bit_cnt_reg <= 4'hF;
    end else if (stop_ev) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && bit_cnt_reg < 4'h8) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end else if (scl_fall) begin
      bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte validity checks
  logic [7:0] wp_new;
  logic wp_valid;
  logic ca_valid;
  assign wp_valid = shift_reg[cfg_lock_pkg::WP_WE_POS] &&
                    (shift_reg[cfg_lock_pkg::WP_CHK_POS] == shift_reg[cfg_lock_pkg::WP_LOCK_POS]);
  // address byte enable and low-bit check
  assign ca_valid = shift_reg[cfg_lock_pkg::CA_WE_POS] &&
                    (shift_reg[cfg_lock_pkg::CA_CHK_POS] == shift_reg[0]);
  assign wp_new = shift_reg & cfg_lock_pkg::WP_STORE_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // transaction state machine
  cfg_lock_pkg::lock_state_t state_reg;
  cfg_lock_pkg::lock_state_t state_next;
  logic ack_bit;
  logic [7:0] pend_wp_reg;
  logic [2:0] pend_ca_reg;
  logic pend_ca_valid_reg;
  cfg_lock_pkg::cfg_state_t cfg_reg;

  always_comb begin
    state_next = state_reg;
    ack_bit = 1'b0;
    case (state_reg)
      cfg_lock_pkg::ST_DEVSEL: begin
        ack_bit = (shift_reg[7:4] == cfg_lock_pkg::DEV_FAMILY_CODE) &&
                  (shift_reg[3:1] == cfg_reg.client_addr) && !shift_reg[0];
        state_next = ack_bit ? cfg_lock_pkg::ST_ADDR_HI : cfg_lock_pkg::ST_IGNORE;
      end
      cfg_lock_pkg::ST_ADDR_HI: begin
        ack_bit = 1'b1;
        // msb of word address selects configuration space
        state_next = shift_reg[cfg_lock_pkg::WADDR_CFG_POS - 8] ? cfg_lock_pkg::ST_ADDR_LO : cfg_lock_pkg::ST_IGNORE;
      end
      cfg_lock_pkg::ST_ADDR_LO: begin
        ack_bit = 1'b1;
        state_next = cfg_lock_pkg::ST_DATA0;
      end
      cfg_lock_pkg::ST_DATA0: begin
        // invalid first byte or already locked: no ack
        ack_bit = wp_valid && !cfg_reg.locked;
        state_next = ack_bit ? cfg_lock_pkg::ST_DATA1 : cfg_lock_pkg::ST_IGNORE;
      end
      cfg_lock_pkg::ST_DATA1: begin
        ack_bit = ca_valid;
        state_next = ack_bit ? cfg_lock_pkg::ST_EXTRA : cfg_lock_pkg::ST_IGNORE;
      end
      cfg_lock_pkg::ST_EXTRA: begin
        state_next = cfg_lock_pkg::ST_IGNORE;
      end
      cfg_lock_pkg::ST_IDLE: state_next = cfg_lock_pkg::ST_IDLE;
      cfg_lock_pkg::ST_IGNORE: state_next = cfg_lock_pkg::ST_IGNORE;
      default: state_next = cfg_lock_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= cfg_lock_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_reg <= cfg_lock_pkg::ST_DEVSEL;
    end else if (stop_ev) begin
      state_reg <= cfg_lock_pkg::ST_IDLE;
    end else if (scl_fall && bit_cnt_reg == 4'h7) begin
      state_reg <= state_reg;
    end else if (byte_done) begin
      state_reg <= state_next;
    end
  end

  // acknowledge drive during ninth bit
  logic ack_drive_reg;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ack_drive_reg <= 1'b0;
    end else if (start_ev || stop_ev || byte_done) begin
      ack_drive_reg <= 1'b0;
    end else if (scl_fall && bit_cnt_reg == 4'h7) begin
      ack_drive_reg <= ack_bit;
    end
  end

  // pending bytes held until stop
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pend_wp_reg <= 8'h00;
      pend_ca_reg <= 3'h0;
      pend_ca_valid_reg <= 1'b0;
    end else if (start_ev) begin
      pend_ca_valid_reg <= 1'b0;
    end else if (byte_done && state_reg == cfg_lock_pkg::ST_DATA0) begin
      pend_wp_reg <= wp_new;
    end else if (byte_done && state_reg == cfg_lock_pkg::ST_DATA1 && ca_valid) begin
      pend_ca_reg <= shift_reg[cfg_lock_pkg::CA_ADDR_HI:0];
      pend_ca_valid_reg <= 1'b1;
    end
  end

  logic commit;
  // stop after data byte 0 or 1 commits
  assign commit = stop_ev && (state_reg == cfg_lock_pkg::ST_DATA1 || state_reg == cfg_lock_pkg::ST_EXTRA) &&
                  !cfg_reg.locked;

  ////////////////////////////////////////////////////////////////////////////
  // configuration store
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg_reg.wp_byte <= cfg_lock_pkg::WP_RESET_VAL;
      cfg_reg.client_addr <= CLIENT_PRESET;
      cfg_reg.locked <= 1'b0;
    end else if (commit) begin
      cfg_reg.wp_byte <= pend_wp_reg;
      if (pend_ca_valid_reg) begin
        cfg_reg.client_addr <= pend_ca_reg;
      end
      if (pend_wp_reg[cfg_lock_pkg::WP_LOCK_POS]) begin
        cfg_reg.locked <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      WP_BYTE <= cfg_lock_pkg::WP_RESET_VAL;
      CLIENT_ADDR <= CLIENT_PRESET;
      CFG_LOCKED <= 1'b0;
      WRITE_CYCLE <= 1'b0;
      ARRAY_FILL <= cfg_lock_pkg::ARRAY_ERASED_VAL;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE <= ack_drive_reg;
      // enable and check bits read zero
      WP_BYTE <= cfg_reg.wp_byte & cfg_lock_pkg::WP_STORE_MASK;
      CLIENT_ADDR <= cfg_reg.client_addr;
      CFG_LOCKED <= cfg_reg.locked;
      WRITE_CYCLE <= commit;
      ARRAY_FILL <= cfg_lock_pkg::ARRAY_ERASED_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_lock_sticky: assert property (@(posedge CLK_SYS) disable iff (RST)
    CFG_LOCKED |=> CFG_LOCKED) else $error("lock cleared");

  a_locked_frozen: assert property (@(posedge CLK_SYS) disable iff (RST)
    cfg_reg.locked |=> $stable(cfg_reg.wp_byte) && $stable(cfg_reg.client_addr))
    else $error("locked config changed");

  a_bad_wp_noack: assert property (@(posedge CLK_SYS) disable iff (RST)
    (scl_fall && bit_cnt_reg == 4'h7 && state_reg == cfg_lock_pkg::ST_DATA0 && !wp_valid) |=> !ack_drive_reg)
    else $error("acked invalid protect byte");

  a_bad_ca_noack: assert property (@(posedge CLK_SYS) disable iff (RST)
    (scl_fall && bit_cnt_reg == 4'h7 && state_reg == cfg_lock_pkg::ST_DATA1 && !ca_valid) |=> !ack_drive_reg)
    else $error("acked invalid address byte");

  a_extra_abort: assert property (@(posedge CLK_SYS) disable iff (RST)
    (byte_done && state_reg == cfg_lock_pkg::ST_EXTRA) |=> state_reg == cfg_lock_pkg::ST_IGNORE)
    else $error("extra byte not aborted");

  a_commit_lock: assert property (@(posedge CLK_SYS) disable iff (RST)
    (commit && pend_wp_reg[0]) |=> ##1 CFG_LOCKED) else $error("lock not committed");

  a_stop_commit: assert property (@(posedge CLK_SYS) disable iff (RST)
    (stop_ev && state_reg == cfg_lock_pkg::ST_DATA1 && !cfg_reg.locked) |=> WRITE_CYCLE)
    else $error("stop did not commit");

  a_addr_kept: assert property (@(posedge CLK_SYS) disable iff (RST)
    (commit && !pend_ca_valid_reg) |=> $stable(cfg_reg.client_addr)) else $error("address changed");

  a_readback_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    WP_BYTE[cfg_lock_pkg::WP_WE_POS] == 1'b0 && WP_BYTE[cfg_lock_pkg::WP_CHK_POS] == 1'b0)
    else $error("enable or check bit read back");

  a_array_fill: assert property (@(posedge CLK_SYS) disable iff (RST)
    ARRAY_FILL == 8'hFF) else $error("array fill wrong");

endmodule

`default_nettype wire

// ==== core/cfg_lock_pkg.sv ====
// package for the configuration lock block: bit layout, reset values, states
// assumes a 40 MHz system clock sampling a slow serial clock
package cfg_lock_pkg;

  localparam int unsigned SYS_CLK_HZ = 40000000;
  // device-select byte: fixed family code in upper nibble, then three address bits, then r/w
  localparam logic [3:0] DEV_FAMILY_CODE = 4'hA;
  // write-protection byte fields
  localparam int unsigned WP_WE_POS = 6;
  localparam int unsigned WP_CHK_POS = 5;
  localparam int unsigned WP_EN_POS = 3;
  localparam int unsigned WP_BLK_HI = 2;
  localparam int unsigned WP_BLK_LO = 1;
  localparam int unsigned WP_LOCK_POS = 0;
  // client-address byte fields
  localparam int unsigned CA_WE_POS = 6;
  localparam int unsigned CA_CHK_POS = 5;
  localparam int unsigned CA_ADDR_HI = 2;
  // stored (readable) masks: write-enable and check bits always read as zero
  localparam logic [7:0] WP_STORE_MASK = 8'h0F;
  localparam logic [7:0] CA_STORE_MASK = 8'h07;
  // factory values
  localparam logic [7:0] WP_RESET_VAL = 8'h00;
  localparam logic [2:0] CA_PRESET_VAL = 3'h0;
  localparam logic [7:0] ARRAY_ERASED_VAL = 8'hFF;
  // word address msb selects configuration space
  localparam int unsigned WADDR_CFG_POS = 15;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEVSEL = 4'h1,
    ST_ADDR_HI = 4'h3,
    ST_ADDR_LO = 4'h2,
    ST_DATA0 = 4'h6,
    ST_DATA1 = 4'h7,
    ST_EXTRA = 4'h5,
    ST_IGNORE = 4'h4
  } lock_state_t;

  typedef struct packed {
    logic [7:0] wp_byte;
    logic [2:0] client_addr;
    logic locked;
  } cfg_state_t;

endpackage

// ==== tb/i2c_host_model.sv ====
// serial bus host model: drives clock and open-drain data, reads the acknowledge
// assumes the bench resolves the data wire with a pull-up from all pull-downs
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // clock idles high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    wait_clk(4);
  endtask
  // data moves only in the middle of the clock low phase
  task automatic put_bit(input logic b, output logic s);
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= ~b;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(2);
    @(negedge clk) s = sda;
    wait_clk(2);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic stop();
    scl <= 1'b0;
    wait_clk(2);
    sda_low <= 1'b1;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(4);
    sda_low <= 1'b0;
    wait_clk(4);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_config_register_lock.sv ====
// self-checking bench for the configuration lock engine
// assumes the host model file is compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_config_register_lock;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, cfg_locked, write_cycle;
  logic [7:0] wp_byte, array_fill, m_wp;
  logic [2:0] client_addr, m_ca;
  logic m_lk;
  logic [31:0] seed = 32'h0000004C;
  int n_errors = 0;
  int checks_done = 0;
  int n_pulse = 0;
  int m_pulse = 0;
  wire sda = ~(sda_low | (sda_oe & ~sda_out));

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (write_cycle === 1'b1) n_pulse <= n_pulse + 1;

  i2c_host_model host (.clk(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
  config_register_lock uut (.CLK_SYS(clk_sys), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .WP_BYTE(wp_byte), .CLIENT_ADDR(client_addr), .CFG_LOCKED(cfg_locked),
    .WRITE_CYCLE(write_cycle), .ARRAY_FILL(array_fill));

  //////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check_regs();
    repeat (12) @(posedge clk_sys);
    check("write pulses", 8'(n_pulse), 8'(m_pulse));
    check("wp byte", wp_byte, m_wp);
    check("client addr", {5'h00, client_addr}, {5'h00, m_ca});
    check("locked", {7'h00, cfg_locked}, {7'h00, m_lk});
    check("array fill", array_fill, cfg_lock_pkg::ARRAY_ERASED_VAL);
  endtask
  // one transaction of n data bytes, stops at the first refused byte
  task automatic xfer(input logic [7:0] dev, input logic [7:0] ah, input logic [7:0] b0,
    input logic [7:0] b1, input int n);
    logic [7:0] bs [6];
    logic a, e, ok;
    bs = '{dev, ah, 8'h00, b0, b1, ~b1};
    ok = 1'b1;
    host.start();
    for (int i = 0; i < n + 3 && ok; i++) begin
      case (i)
        0: e = (bs[0] === {cfg_lock_pkg::DEV_FAMILY_CODE, m_ca, 1'b0});
        1: e = 1'b1;
        2: e = bs[1][7];
        3: e = bs[3][6] & (bs[3][5] == bs[3][0]) & ~m_lk;
        4: e = bs[4][6] & (bs[4][5] == bs[4][0]);
        default: e = 1'b0;
      endcase
      host.send_byte(bs[i], a);
      check("ack", {7'h00, a}, {7'h00, e});
      ok = a & e;
    end
    host.stop();
    // model of the commit after the stop
    if (ok && !m_lk) begin
      m_wp = b0 & cfg_lock_pkg::WP_STORE_MASK;
      if (n == 2) m_ca = b1[2:0];
      m_lk = b0[0];
      m_pulse++;
    end
    check_regs();
  endtask

  //////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] dev, ah, b0, b1;
    int n;
    m_wp = cfg_lock_pkg::WP_RESET_VAL;
    m_ca = cfg_lock_pkg::CA_PRESET_VAL;
    m_lk = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("reset ack", {7'h00, sda_oe}, 8'h00);
    check_regs();
    for (int t = 0; t < 30; t++) begin
      seed = xs(seed);
      dev = {cfg_lock_pkg::DEV_FAMILY_CODE, m_ca ^ {2'b00, seed[0] & seed[1]}, seed[28] & seed[29]};
      ah = {seed[2] | seed[3], 7'h00};
      b0 = (seed[15:8] & 8'hFE) | {1'b0, seed[7] | seed[6], 6'h00};
      b1 = seed[23:16] | {1'b0, seed[5] | seed[4], 6'h00};
      n = 1 + int'(seed[27:26]) % 3;
      if (t >= 22) b0[0] = seed[9];
      // lock with both bits set and no address byte
      if (t == 20) begin
        dev[3:1] = m_ca;
        dev[0] = 1'b0;
        ah = 8'h80;
        b0 = 8'h61 | (seed[15:8] & 8'h0E);
        n = 1;
      end
      xfer(dev, ah, b0, b1, n);
      $display("test %0d done", t);
    end
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
